// >>> qdd_channel.sv
// one decoder channel: input filter, gray-code step and 8-bit counter
// assumes sample_i is a one-cycle pulse from the prescaler timer
module qdd_channel
    import qdd_pkg::*;
#(
    parameter int unsigned CNT_W = QDD_CNT_W
)
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic sample_i,
    input wire logic enable_i,
    input wire qdd_pair_type raw_i,
    input wire logic clear_i,
    output logic [CNT_W-1:0] count_o,
    output qdd_wrap_type wrap_o
);
    // the reset value constant is only as wide as the documented counter
    if (CNT_W < 2 || CNT_W > $bits(QDD_CNT_RESET))
    begin : g_bad_width
        $error("counter width out of range");
    end

    qdd_pair_type samp_q;
    qdd_pair_type filt_q;
    qdd_pair_type filt_d;
    logic primed_q;
    logic [CNT_W-1:0] count_q;
    logic step_up;
    logic step_dn;
    localparam logic [CNT_W-1:0] ONE = {{(CNT_W-1){1'b0}}, 1'b1};
    localparam logic [CNT_W-1:0] ZERO = '0;
    localparam logic [CNT_W-1:0] FULL = '1;

    // --------------------------------------------------------------
    // input filter
    // --------------------------------------------------------------
    // a level passes only after two equal samples, so shorter pulses die
    always_comb
    begin
        filt_d = filt_q;
        if (samp_q.in_phase == raw_i.in_phase)
        begin
            filt_d.in_phase = raw_i.in_phase;
        end
        if (samp_q.quad == raw_i.quad)
        begin
            filt_d.quad = raw_i.quad;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            samp_q <= '0;
            filt_q <= '0;
        end
        else if (sample_i)
        begin
            samp_q <= raw_i;
            // until primed the filter is re-seeded from the pins, so a
            // change of nibble on enabling never settles into a step
            filt_q <= (enable_i && primed_q) ? filt_d : raw_i;
        end
    end

    // disabled channel holds its count; the first enabled sample re-seeds
    // the reference without stepping, so enable changes never count
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            primed_q <= 1'b0;
        end
        else if (!enable_i)
        begin
            primed_q <= 1'b0;
        end
        else if (sample_i)
        begin
            primed_q <= 1'b1;
        end
    end

    // --------------------------------------------------------------
    // direction decode
    // --------------------------------------------------------------
    // forward gray order 00-01-11-10 on (in_phase, quad)
    always_comb
    begin
        step_up = 1'b0;
        step_dn = 1'b0;
        if (sample_i && enable_i && primed_q && filt_d != filt_q)
        begin
            step_up = (filt_q.in_phase ^ filt_d.quad);
            step_dn = ~step_up;
        end
    end

    // --------------------------------------------------------------
    // counter
    // --------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            count_q <= QDD_CNT_RESET[CNT_W-1:0];
        end
        else if (clear_i)
        begin
            count_q <= ZERO;
        end
        else if (step_up)
        begin
            count_q <= count_q + ONE;
        end
        else if (step_dn)
        begin
            count_q <= count_q - ONE;
        end
    end

    // one-cycle wrap events; a clear suppresses them
    always_comb
    begin
        wrap_o.up = !clear_i && step_up && count_q == FULL;
        wrap_o.down = !clear_i && step_dn && count_q == ZERO;
    end

    assign count_o = count_q;
endmodule

// >>> qdd_checker.sv
// port-level assertions for the dual quadrature decoder
// assumes one clock domain and the top module's port names
module qdd_checker
    import qdd_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic prescaler_timer_output_i,
    input wire logic [7:0] io_addr_i,
    input wire logic [7:0] io_wdata_i,
    input wire logic io_wr_i,
    input wire logic io_rd_i,
    input wire logic [7:0] io_rdata_o,
    input wire logic irq_o,
    input wire logic [1:0] irq_priority_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    logic rd_st;
    logic rd_map;
    assign rd_st = io_rd_i && io_addr_i == QDD_ADDR_STATUS;
    assign rd_map = io_addr_i inside {QDD_ADDR_STATUS, QDD_ADDR_CTRL,
        QDD_ADDR_CNT1, QDD_ADDR_CNT2};
    prio_from_ctrl_a: assert property (
        io_wr_i && io_addr_i == QDD_ADDR_CTRL
        |=> irq_priority_o == $past(io_wdata_i[1:0]))
        else $error("priority differs from control write");
    irq_masked_a: assert property (
        irq_priority_o == QDD_PRI_OFF |-> !irq_o)
        else $error("interrupt while disabled");
    // a read away from sample pulses must leave no wrap pending
    read_clears_a: assert property (
        rd_st && !prescaler_timer_output_i
        && !$past(prescaler_timer_output_i) |=> !irq_o)
        else $error("status read left interrupt up");
    zero_bits_a: assert property (
        rd_st |=> io_rdata_o[5] == 1'b0 && io_rdata_o[1] == 1'b0)
        else $error("status bits 5 or 1 not zero");
    irq_has_cause_a: assert property (
        rd_st && irq_o |=> (io_rdata_o & 8'hCC) != 8'h00)
        else $error("interrupt without wrap flag");
    rdata_holds_a: assert property (
        !io_rd_i |=> $stable(io_rdata_o))
        else $error("read data moved without read");
    unmapped_zero_a: assert property (
        io_rd_i && !rd_map |=> io_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    irq_on_sample_a: assert property (
        $rose(irq_o) && $stable(irq_priority_o)
        |-> $past(prescaler_timer_output_i)
        || $past(prescaler_timer_output_i, 2))
        else $error("interrupt rose away from sample pulse");
endmodule
bind qdd_dual_quadrature_decoder qdd_checker qdd_checker_i (.clk_i,
    .reset_n_i, .prescaler_timer_output_i, .io_addr_i, .io_wdata_i,
    .io_wr_i, .io_rd_i, .io_rdata_o, .irq_o, .irq_priority_o);

// >>> qdd_dual_quadrature_decoder.sv
// top of the dual quadrature decoder: i/o registers and pin routing
// assumes io strobes are one-cycle pulses synchronous to clk_i
module qdd_dual_quadrature_decoder
    import qdd_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic prescaler_timer_output_i,
    input wire logic [7:0] port_i,
    input wire logic [7:0] io_addr_i,
    input wire logic [7:0] io_wdata_i,
    input wire logic io_wr_i,
    input wire logic io_rd_i,
    output logic [7:0] io_rdata_o,
    output logic irq_o,
    output logic [1:0] irq_priority_o
);
    logic [7:0] ctrl_q;
    logic [7:0] status_q;
    logic [7:0] rdata_q;
    logic wr_status;
    logic rd_status;
    logic [1:0] sel [2];
    logic [1:0] clr;
    qdd_pair_type raw [2];
    qdd_wrap_type wrap [2];
    logic [7:0] count [2];

    assign wr_status = io_wr_i && io_addr_i == QDD_ADDR_STATUS;
    assign rd_status = io_rd_i && io_addr_i == QDD_ADDR_STATUS;
    assign sel[0] = ctrl_q[QDD_CT_C1_SEL +: 2];
    assign sel[1] = ctrl_q[QDD_CT_C2_SEL +: 2];
    assign clr[0] = wr_status && io_wdata_i[QDD_ST_C1_CLR];
    assign clr[1] = wr_status && io_wdata_i[QDD_ST_C2_CLR];

    // --------------------------------------------------------------
    // pin routing and channels
    // --------------------------------------------------------------
    // channel 0 uses nibble bits 1:0 or 5:4, channel 1 bits 3:2 or 7:6
    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_ch
            localparam int unsigned LO = 2 * g;
            always_comb
            begin
                if (sel[g] == QDD_SEL_HIGH)
                begin
                    raw[g].in_phase = port_i[LO + 5];
                    raw[g].quad = port_i[LO + 4];
                end
                else
                begin
                    raw[g].in_phase = port_i[LO + 1];
                    raw[g].quad = port_i[LO];
                end
            end

            qdd_channel #(
                .CNT_W(QDD_CNT_W)
            ) u_ch (
                .clk_i(clk_i),
                .reset_n_i(reset_n_i),
                .sample_i(prescaler_timer_output_i),
                .enable_i(sel[g][1]),
                .raw_i(raw[g]),
                .clear_i(clr[g]),
                .count_o(count[g]),
                .wrap_o(wrap[g])
            );
        end
    endgenerate

    // --------------------------------------------------------------
    // control register
    // --------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            ctrl_q <= QDD_CTRL_RESET;
        end
        else if (io_wr_i && io_addr_i == QDD_ADDR_CTRL)
        begin
            ctrl_q <= io_wdata_i & 8'hCF;
        end
    end

    // --------------------------------------------------------------
    // wrap status
    // --------------------------------------------------------------
    // a wrap in the cycle of the clearing read stays set: set wins
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            status_q <= '0;
        end
        else
        begin
            // unused and write-only positions stay zero
            status_q <= '0;
            status_q[QDD_ST_C2_UP] <= wrap[1].up ||
                (status_q[QDD_ST_C2_UP] && !rd_status);
            status_q[QDD_ST_C2_DN] <= wrap[1].down ||
                (status_q[QDD_ST_C2_DN] && !rd_status);
            status_q[QDD_ST_C1_UP] <= wrap[0].up ||
                (status_q[QDD_ST_C1_UP] && !rd_status);
            status_q[QDD_ST_C1_DN] <= wrap[0].down ||
                (status_q[QDD_ST_C1_DN] && !rd_status);
        end
    end

    // --------------------------------------------------------------
    // read data
    // --------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            rdata_q <= 8'h00;
        end
        else if (io_rd_i)
        begin
            case (io_addr_i)
                QDD_ADDR_STATUS: rdata_q <= status_q;
                QDD_ADDR_CNT1: rdata_q <= count[0];
                QDD_ADDR_CNT2: rdata_q <= count[1];
                default: rdata_q <= 8'h00;
            endcase
        end
    end

    assign io_rdata_o = rdata_q;
    // interrupt follows status and is gated by the priority field
    assign irq_o = (ctrl_q[QDD_CT_PRI +: 2] != QDD_PRI_OFF) &&
        (status_q != 8'h00);
    assign irq_priority_o = ctrl_q[QDD_CT_PRI +: 2];
endmodule

// >>> qdd_encoder_model.sv
// two incremental shaft encoders driving the decoder's port pins
// assumes steps are one-cycle pulses spaced several sample periods apart
module qdd_encoder_model (
    input wire logic clk_i,
    input wire logic [1:0] step_i,
    input wire logic [1:0] dir_i,
    input wire logic [1:0] hi_i,
    input wire logic [7:0] glitch_i,
    output logic [7:0] port_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] pos [2] = '{2'h0, 2'h0};
    always @(posedge clk_i)
        for (int c = 0; c < 2; c++)
            if (step_i[c])
                pos[c] <= dir_i[c] ? pos[c] + 2'h1 : pos[c] - 2'h1;
    // gray code moves one line per step; unused pins follow glitch_i
    always_comb
    begin
        port_o = glitch_i;
        port_o[(hi_i[0] ? 4 : 0) +: 2] ^= {pos[0][1], ^pos[0]};
        port_o[(hi_i[1] ? 6 : 2) +: 2] ^= {pos[1][1], ^pos[1]};
    end
endmodule

// >>> qdd_pkg.sv
// constants, field layouts and carrier types of the dual quadrature decoder
// assumes an 8-bit processor i/o port with one-cycle read and write strobes
// Functional notes
// - two independent channels, each with one 8-bit position counter
// - sampling and counting happen only on prescaler timer pulses
// - each input filter rejects pulses shorter than one sample period
// - a channel takes two bits of one nibble; in-phase on odd bit, quadrature on even
// - entering, leaving or rewriting disabled selection never moves the counter
// - a wrap from FFh to 00h or from 00h to FFh raises the interrupt
// - status bits set with the interrupt; a status read clears both
// - status bit 7 marks channel two up-wrap, bit 6 its down-wrap
// - status bit 3 marks channel one up-wrap, bit 2 its down-wrap
// - status bits 5 and 1 always read zero
// - writing one to bit 4 or 0 clears channel two or one counter
// - control 7:6 picks channel two: 0x off, 10 bits 3:2, 11 bits 7:6
// - control 3:2 picks channel one: 0x off, 10 bits 1:0, 11 bits 5:4
// - control bits 5:4 are ignored
// - control 1:0 sets interrupt: 00 off, else priority 1 to 3
// - count registers at 0x94 and 0x96 return the live counter value
package qdd_pkg;
    localparam int unsigned QDD_CNT_W = 8;
    localparam logic [7:0] QDD_ADDR_STATUS = 8'h90;
    localparam logic [7:0] QDD_ADDR_CTRL = 8'h91;
    localparam logic [7:0] QDD_ADDR_CNT1 = 8'h94;
    localparam logic [7:0] QDD_ADDR_CNT2 = 8'h96;
    // status bit positions
    localparam int unsigned QDD_ST_C2_UP = 7;
    localparam int unsigned QDD_ST_C2_DN = 6;
    localparam int unsigned QDD_ST_C2_CLR = 4;
    localparam int unsigned QDD_ST_C1_UP = 3;
    localparam int unsigned QDD_ST_C1_DN = 2;
    localparam int unsigned QDD_ST_C1_CLR = 0;
    // control field positions (low bit of each 2-bit field)
    localparam int unsigned QDD_CT_C2_SEL = 6;
    localparam int unsigned QDD_CT_C1_SEL = 2;
    localparam int unsigned QDD_CT_PRI = 0;
    localparam logic [1:0] QDD_SEL_LOW = 2'h2;
    localparam logic [1:0] QDD_SEL_HIGH = 2'h3;
    localparam logic [1:0] QDD_PRI_OFF = 2'h0;
    localparam logic [7:0] QDD_CTRL_RESET = 8'h00;
    localparam logic [7:0] QDD_CNT_RESET = 8'h00;
    localparam logic [7:0] QDD_CNT_MAX = 8'hFF;

    // one channel's filtered pair
    typedef struct packed {
        logic in_phase;
        logic quad;
    } qdd_pair_type;

    // wrap events of one channel
    typedef struct packed {
        logic up;
        logic down;
    } qdd_wrap_type;
endpackage

// >>> tb_dual_quadrature_decoder.sv
// random and corner stimulus for the dual quadrature decoder
// assumes a 40 ns clock and a prescaler pulse every fourth cycle
module tb_dual_quadrature_decoder
    import qdd_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 1'b0, reset_n_i = 1'b0, wr = 1'b0, rd = 1'b0, irq;
    logic [1:0] pc = 2'h0, stp = 2'h0, dir = 2'h0, hi = 2'h0, pri;
    logic [7:0] addr = 8'h00, wd = 8'h00, gl = 8'h00, st = 8'h00;
    logic [7:0] port, rdata, v;
    logic [7:0] cnt [2] = '{8'h00, 8'h00};
    logic [31:0] rs = 32'hD8C4ABD9;
    int n_errors = 0, comparisons = 0;
    always #20 clk_i = ~clk_i;
    always @(posedge clk_i) #1 pc = pc + 2'h1;
    qdd_dual_quadrature_decoder qdd_dual_quadrature_decoder_i (
        .clk_i(clk_i), .reset_n_i(reset_n_i),
        .prescaler_timer_output_i(pc == 2'h0), .port_i(port),
        .io_addr_i(addr), .io_wdata_i(wd), .io_wr_i(wr), .io_rd_i(rd),
        .io_rdata_o(rdata), .irq_o(irq), .irq_priority_o(pri));
    qdd_encoder_model qdd_encoder_model_i (.clk_i(clk_i), .step_i(stp),
        .dir_i(dir), .hi_i(hi), .glitch_i(gl), .port_o(port));
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    // one gray step moves the count by one, wrapping at eight bits
    function automatic logic [7:0] next_cnt(input logic [7:0] c,
        input logic d);
        return d ? c + 8'h01 : c - 8'h01;
    endfunction
    task chk(input string n, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e)
        begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i) #1 addr = a;
        wd = d;
        wr = 1'b1;
        @(posedge clk_i) #1 wr = 1'b0;
    endtask
    task rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i) #1 addr = a;
        rd = 1'b1;
        @(posedge clk_i) #1 rd = 1'b0;
        d = rdata;
    endtask
    task mv(input int c, input logic d);
        @(posedge clk_i) #1 stp[c] = 1'b1;
        dir[c] = d;
        @(posedge clk_i) #1 stp[c] = 1'b0;
    endtask
    task chk_cnts;
        rd_reg(QDD_ADDR_CNT1, v);
        chk("count1", cnt[0], v);
        rd_reg(QDD_ADDR_CNT2, v);
        chk("count2", cnt[1], v);
    endtask
    // steps stay five sample periods apart so the filter settles
    task do_step(input int c, input logic d);
        mv(c, d);
        if (d && cnt[c] == 8'hFF)
            st[c ? 7 : 3] = 1'b1;
        if (!d && cnt[c] == 8'h00)
            st[c ? 6 : 2] = 1'b1;
        cnt[c] = next_cnt(cnt[c], d);
        repeat (20) @(posedge clk_i);
        #1 chk("irq", {7'h00, st != 8'h00}, {7'h00, irq});
        rd_reg(c ? QDD_ADDR_CNT2 : QDD_ADDR_CNT1, v);
        chk("count", cnt[c], v);
        rd_reg(QDD_ADDR_STATUS, v);
        chk("status", st, v);
        st = 8'h00;
    endtask
    task print_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        #400000;
        n_errors++;
        print_verdict();
    end
    initial
    begin
        repeat (3) @(posedge clk_i);
        #1 reset_n_i = 1'b1;
        wr_reg(QDD_ADDR_CNT1, 8'hFF);
        chk_cnts();
        rd_reg(QDD_ADDR_STATUS, v);
        chk("status", 8'h00, v);
        rd_reg(8'h92, v);
        chk("unmapped", 8'h00, v);
        $display("test reset done");
        for (int i = 0; i < 4; i++)
        begin
            rs = xs(rs);
            wr_reg(QDD_ADDR_CTRL, 8'h88 | (rs[7:0] & 8'h30) | 8'(i ^ 2));
            chk("priority", 8'(i ^ 2), {6'h00, pri});
        end
        $display("test control done");
        repeat (20) @(posedge clk_i);
        for (int k = 0; k < 2; k++)
        begin
            for (int c = 0; c < 2; c++)
            begin
                do_step(c, 1'b0);
                do_step(c, 1'b1);
            end
            for (int i = 0; i < 20; i++)
            begin
                rs = xs(rs);
                do_step(int'(rs[0]), rs[1]);
            end
            $display("test stepping done");
            if (k == 0)
            begin
                @(posedge clk_i) #1 gl = 8'hFF;
                repeat (4) @(posedge clk_i);
                #1 gl = 8'h00;
                repeat (20) @(posedge clk_i);
                chk_cnts();
                wr_reg(QDD_ADDR_CTRL, 8'h01);
                hi = 2'h3;
                mv(0, 1'b1);
                mv(1, 1'b0);
                wr_reg(QDD_ADDR_CTRL, 8'h45);
                repeat (20) @(posedge clk_i);
                chk_cnts();
                wr_reg(QDD_ADDR_CTRL, 8'hCD);
                repeat (20) @(posedge clk_i);
                chk_cnts();
                $display("test glitch and disable done");
            end
        end
        wr_reg(QDD_ADDR_STATUS, 8'h01);
        cnt[0] = 8'h00;
        chk_cnts();
        wr_reg(QDD_ADDR_STATUS, 8'h10);
        cnt[1] = 8'h00;
        chk_cnts();
        chk("irq", 8'h00, {7'h00, irq});
        $display("test clear done");
        print_verdict();
    end
endmodule
